/* hdl/fault_status_pkg.sv */
// ============================================================================
// Shared constants, types and field positions of the fault and status words.
// ============================================================================
package fault_status_pkg;

  // ==========================================================================
  // Sizes.
  // ==========================================================================
  localparam int NUM_CH = 16;
  localparam int ALARM_W = 5;

  // ==========================================================================
  // Wiring modes and data formats.
  // ==========================================================================
  typedef enum logic [1:0]
  {
    WIRE_SINGLE = 2'b00,
    WIRE_DIFF = 2'b01,
    WIRE_HS_DIFF = 2'b10
  } wiring_t;

  typedef enum logic
  {
    FMT_FLOAT = 1'b0,
    FMT_INTEGER = 1'b1
  } data_format_t;

  // ==========================================================================
  // Channel fault word patterns and channel masks.
  // ==========================================================================
  localparam logic [15:0] CAL_PATTERN_SINGLE = 16'hFFFF;
  localparam logic [15:0] CAL_PATTERN_DIFF = 16'h00FF;
  localparam logic [15:0] CAL_PATTERN_HS_DIFF = 16'h000F;
  localparam logic [15:0] COMMS_PATTERN = 16'hFFFF;
  localparam logic [15:0] CHANNEL_FAULT_RESET = 16'h0000;

  // ==========================================================================
  // Module fault word bit positions.
  // ==========================================================================
  localparam int MOD_GROUP_FAULT_BIT = 15;
  localparam int MOD_CALIBRATING_BIT = 10;
  localparam int MOD_CAL_ERROR_BIT = 9;
  localparam logic [15:0] MODULE_FAULT_RESET = 16'h0000;

  // ==========================================================================
  // Per-channel status byte bit positions (alarm bits sit at 4 down to 0).
  // ==========================================================================
  localparam int ST_CAL_ERROR_BIT = 7;
  localparam int ST_UNDER_BIT = 6;
  localparam int ST_OVER_BIT = 5;
  localparam int ALM_SLOPE = 4;
  localparam int ALM_LOW = 3;
  localparam int ALM_HIGH = 2;
  localparam int ALM_LOW_LOW = 1;
  localparam int ALM_HIGH_HIGH = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ==========================================================================
  // Integer-mode packed word: channel n overrange at 30 - 2n, underrange above.
  // ==========================================================================
  localparam int PACK_OVER_BASE = 30;
  localparam logic [31:0] PACKED_RESET = 32'h0000_0000;

  // Conditions delivered by the conversion path for one channel each update.
  typedef struct packed
  {
    logic at_min;
    logic at_max;
    logic [ALARM_W-1:0] trip;
    logic [ALARM_W-1:0] clear_ok;
  } chan_cond_t;

endpackage

/* hdl/fault_status_aggregator.sv */
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Range condition sets channel fault bit normally.
// - Calibration forces FFFF, 00FF or 000F.
// - Communication loss forces channel faults to FFFF.
// - Status range bit also sets channel fault.
// - Channel cal error sets module cal error.
// - Bad calibration sets the channel cal error.
// - Input at minimum sets underrange bit.
// - Input at maximum sets overrange bit.
// - Slope alarm follows rate, optionally latched.
// - Low alarm with deadband clear and latch.
// - High alarm with deadband clear and latch.
// - Low-low alarm with deadband clear and latch.
// - High-high alarm with deadband clear and latch.
// - Float single-ended mode drops all alarm bits.
// - Group fault set by any channel fault.
// - Calibrating bit set during any calibration.
// - Module cal error is OR of the channels in use.
// - Module fault bits 14 to 11 read zero.
// - Channel fault width follows wiring, channel 0 bit 0.
// - Integer mode keeps module and channel fault words.
// - Integer overrange at 30-2n, underrange above.
// - Integer mode reports only range per channel.
// - Packed integer word is 32 bits, channel 0 top.
module fault_status_aggregator
  import fault_status_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic update_tick,
  input wire wiring_t wiring_mode,
  input wire data_format_t data_format,
  input wire logic comms_fault,
  input wire logic cal_busy,
  input wire logic [CHANNELS-1:0] cal_done,
  input wire logic [CHANNELS-1:0] cal_bad,
  input wire chan_cond_t [CHANNELS-1:0] chan_cond,
  input wire logic [CHANNELS-1:0][ALARM_W-1:0] alarm_latch_en,
  input wire logic [CHANNELS-1:0][ALARM_W-1:0] alarm_unlatch,
  output logic [15:0] module_fault_summary,
  output logic [15:0] channel_fault_vector,
  output logic [CHANNELS-1:0][7:0] per_channel_status,
  output logic [31:0] packed_range_status_integer
);

  // ==========================================================================
  // Helper functions.
  // ==========================================================================

  // Channels in use for a wiring mode; the rest read as zero except in the comms loss pattern FFFF.
  function automatic logic [15:0] active_mask(input wiring_t mode);
    logic [15:0] m;
    m = CAL_PATTERN_SINGLE;
    case (mode)
      WIRE_SINGLE: m = CAL_PATTERN_SINGLE;
      WIRE_DIFF: m = CAL_PATTERN_DIFF;
      WIRE_HS_DIFF: m = CAL_PATTERN_HS_DIFF;
      default: m = CAL_PATTERN_SINGLE;
    endcase
    return m;
  endfunction

  // Next value of one alarm bit. A trip wins over both clear and unlatch, so an
  // event in the same update as an unlatch request is never lost.
  function automatic logic next_alarm(input logic cur, input logic trip,
                                      input logic clear_ok, input logic latch,
                                      input logic unlatch);
    logic n;
    n = cur;
    if (trip)
    begin
      n = 1'b1;
    end
    else if (latch)
    begin
      // A latched alarm holds until software unlatches it.
      n = cur & ~unlatch;
    end
    else if (clear_ok)
    begin
      // Unlatched alarm clears once past the trigger point and deadband.
      n = 1'b0;
    end
    return n;
  endfunction

  // ==========================================================================
  // Internal state.
  // ==========================================================================

  // Calibration error per channel, kept even in integer mode for the module bit.
  logic [CHANNELS-1:0] chan_cal_error;
  // Alarm state per channel, bit order as in the status byte.
  logic [CHANNELS-1:0][ALARM_W-1:0] alarm_state;
  // Alarm state that the next update will hold.
  logic [CHANNELS-1:0][ALARM_W-1:0] next_alarm_state;
  // True while alarms are offered at all.
  logic alarms_enabled;
  // Next values of the published words.
  logic [15:0] next_channel_fault;
  logic [15:0] next_module_fault;
  logic [15:0] range_fault;
  logic [15:0] mask;
  logic [CHANNELS-1:0][7:0] next_status;
  logic [31:0] next_packed;

  // Alarms exist only outside float single-ended mode and never in integer mode.
  // The unused wiring code counts as single-ended, so it offers no alarms either.
  assign alarms_enabled = (data_format == FMT_FLOAT) && (wiring_mode == WIRE_DIFF || wiring_mode == WIRE_HS_DIFF);

  // ==========================================================================
  // Calibration error per channel.
  // ==========================================================================

  // Each finished calibration replaces the channel's verdict, so a later good
  // calibration clears an earlier error. The flag changes only on cal_done.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_cal_error <= '0;
    end
    else
    begin
      for (int ch = 0; ch < CHANNELS; ch++)
      begin
        if (cal_done[ch])
        begin
          chan_cal_error[ch] <= cal_bad[ch];
        end
      end
    end
  end

  // ==========================================================================
  // Alarm state per channel.
  // ==========================================================================

  // Next alarm state of every channel, built from the state held since the
  // last update. The status byte takes this value on the same tick, so a new
  // alarm is visible one cycle after the update that raised it, not two.
  always_comb
  begin
    next_alarm_state = '0;
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      for (int a = 0; a < ALARM_W; a++)
      begin
        if (alarms_enabled)
        begin
          // Slope alarm (4), low (3), high (2), low-low (1), high-high (0).
          next_alarm_state[ch][a] = next_alarm(alarm_state[ch][a],
                                               chan_cond[ch].trip[a],
                                               chan_cond[ch].clear_ok[a],
                                               alarm_latch_en[ch][a],
                                               alarm_unlatch[ch][a]);
        end
        else
        begin
          // A mode without alarms leaves the state wiped.
          next_alarm_state[ch][a] = 1'b0;
        end
      end
    end
  end

  // Alarms advance once per update cycle. When the mode removes alarms the
  // state is wiped, so no stale alarm reappears on a later mode change.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_state <= '0;
    end
    else if (update_tick)
    begin
      alarm_state <= next_alarm_state;
    end
  end

  // ==========================================================================
  // Combinational build of the next words.
  // ==========================================================================

  // Range faults are taken fresh every update and hold no memory of their own,
  // so they vanish as soon as the condition is gone.
  always_comb
  begin
    mask = active_mask(wiring_mode);
    range_fault = '0;
    next_packed = '0;
    next_status = '0;
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      if (mask[ch])
      begin
        range_fault[ch] = chan_cond[ch].at_min | chan_cond[ch].at_max;
        if (data_format == FMT_INTEGER)
        begin
          // Channel 0 takes the top pair; underrange on odd positions.
          next_packed[PACK_OVER_BASE - 2 * ch] = chan_cond[ch].at_max;
          next_packed[PACK_OVER_BASE - 2 * ch + 1] = chan_cond[ch].at_min;
        end
        else
        begin
          next_status[ch][ST_CAL_ERROR_BIT] = chan_cal_error[ch];
          next_status[ch][ST_UNDER_BIT] = chan_cond[ch].at_min;
          next_status[ch][ST_OVER_BIT] = chan_cond[ch].at_max;
          next_status[ch][ALARM_W-1:0] = next_alarm_state[ch] & {ALARM_W{alarms_enabled}};
        end
      end
    end
    // Communications loss outranks calibration; both outrank range faults.
    if (comms_fault)
    begin
      next_channel_fault = COMMS_PATTERN;
    end
    else if (cal_busy)
    begin
      next_channel_fault = mask;
    end
    else
    begin
      next_channel_fault = range_fault;
    end
    // The module word is built the same way in both data formats.
    next_module_fault = MODULE_FAULT_RESET;
    next_module_fault[MOD_GROUP_FAULT_BIT] = |next_channel_fault;
    next_module_fault[MOD_CALIBRATING_BIT] = cal_busy;
    next_module_fault[MOD_CAL_ERROR_BIT] = |(chan_cal_error & mask[CHANNELS-1:0]);
  end

  // ==========================================================================
  // Published words.
  // ==========================================================================

  // All words are sampled together on the update tick, so the owner always
  // receives one consistent snapshot of every level.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel_fault_vector <= CHANNEL_FAULT_RESET;
      module_fault_summary <= MODULE_FAULT_RESET;
    end
    else if (update_tick)
    begin
      channel_fault_vector <= next_channel_fault;
      module_fault_summary <= next_module_fault;
    end
  end

  // Per-channel bytes and the packed word carry only the current format.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_channel_status <= {CHANNELS{STATUS_RESET}};
      packed_range_status_integer <= PACKED_RESET;
    end
    else if (update_tick)
    begin
      per_channel_status <= next_status;
      packed_range_status_integer <= next_packed;
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // A lost link shows all ones on the next update.
  a_comms_force_ones: assert property (update_tick && comms_fault |=> channel_fault_vector == 16'hFFFF)
    else $error("channel fault word not all ones during comms loss");

  // Calibration pattern depends on wiring mode.
  a_cal_pattern_mode: assert property (update_tick && !comms_fault && cal_busy && wiring_mode == WIRE_DIFF
                                       |=> channel_fault_vector == 16'h00FF)
    else $error("differential calibration pattern wrong");

  // High speed pattern.
  a_cal_pattern_hsd: assert property (update_tick && !comms_fault && cal_busy && wiring_mode == WIRE_HS_DIFF
                                      |=> channel_fault_vector == 16'h000F)
    else $error("high speed calibration pattern wrong");

  // Calibrating bit follows the busy input.
  a_calibrating_bit: assert property (update_tick |=> module_fault_summary[10] == $past(cal_busy))
    else $error("calibrating bit does not follow calibration");

  // Group fault mirrors any channel fault bit.
  a_group_fault_or: assert property (module_fault_summary[15] == (|channel_fault_vector))
    else $error("group fault does not match channel fault word");

  // Unused module bits stay zero.
  a_unused_bits_zero: assert property (module_fault_summary[14:11] == 4'h0)
    else $error("unused module fault bits set");

  // Normal range fault on channel 0 appears in bit 0.
  a_range_sets_fault: assert property (update_tick && !comms_fault && !cal_busy && chan_cond[0].at_max
                                       |=> channel_fault_vector[0])
    else $error("overrange did not set channel fault bit");

  // Range faults clear once the cause is gone.
  a_range_self_clear: assert property (update_tick && !comms_fault && !cal_busy && wiring_mode == WIRE_HS_DIFF
                                       && !chan_cond[3].at_min && !chan_cond[3].at_max
                                       |=> !channel_fault_vector[3])
    else $error("channel fault bit stuck after condition cleared");

  // Integer channel 0 overrange lands at bit 30.
  a_packed_ch0_over: assert property (update_tick && data_format == FMT_INTEGER
                                      |=> packed_range_status_integer[30] == $past(chan_cond[0].at_max))
    else $error("integer packed overrange misplaced");

  // No alarms in float single-ended mode.
  a_no_alarm_se: assert property (update_tick && data_format == FMT_FLOAT && wiring_mode == WIRE_SINGLE
                                  |=> per_channel_status[0][4:0] == 5'h00)
    else $error("alarm bits present in single-ended float mode");

  // Channel cal error reaches module bit on the update one cycle after cal_done.
  a_cal_error_up: assert property ((cal_done & cal_bad & mask[CHANNELS-1:0]) != '0
                                   ##1 update_tick && $stable(wiring_mode) |=> module_fault_summary[9])
    else $error("module calibration error not set");

  // A low alarm trip shows in the status byte on the next update.
  a_alarm_trip_seen: assert property (update_tick && alarms_enabled && chan_cond[1].trip[ALM_LOW]
                                      |=> per_channel_status[1][ALM_LOW])
    else $error("low alarm trip not shown in status byte");

  // A latched high alarm holds until it is unlatched.
  a_latched_hold: assert property (update_tick && alarms_enabled && alarm_latch_en[1][ALM_HIGH]
                                   && per_channel_status[1][ALM_HIGH] && !alarm_unlatch[1][ALM_HIGH]
                                   |=> per_channel_status[1][ALM_HIGH])
    else $error("latched high alarm dropped without unlatch");

  // Integer mode carries no per-channel status bytes.
  a_integer_no_status: assert property (update_tick && data_format == FMT_INTEGER
                                        |=> per_channel_status[2] == 8'h00)
    else $error("status byte present in integer mode");

  cover_comms_loss: cover property (update_tick && comms_fault ##1 channel_fault_vector == 16'hFFFF);
  cover_cal_single: cover property (update_tick && cal_busy && wiring_mode == WIRE_SINGLE && !comms_fault);
  cover_alarm_latched: cover property (alarm_state[1][ALM_LOW] && alarm_latch_en[1][ALM_LOW] && update_tick);
  cover_integer_under: cover property (packed_range_status_integer[31]);

endmodule

`default_nettype wire

/* tb/owner_controller_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Owner controller: takes each multicast frame of fault words off the link.
// ============================================================================
module owner_controller_model
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic update_tick,
  input wire logic [15:0] module_fault_summary,
  input wire logic [15:0] channel_fault_vector,
  output logic [15:0] rx_module,
  output logic [15:0] rx_channel
);
  // High in the cycle where the device's answer to a tick stands.
  logic tick_seen;

  // The frame is taken one cycle after the tick, never at the tick itself,
  // because the words only settle after the device has sampled the update.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_seen <= 1'b0;
      rx_module <= 16'h0000;
      rx_channel <= 16'h0000;
    end
    else
    begin
      tick_seen <= update_tick;
      if (tick_seen)
      begin
        rx_module <= module_fault_summary;
        rx_channel <= channel_fault_vector;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Self-checking bench for the fault and status aggregator.
// ============================================================================
module tb;
  import fault_status_pkg::*;

  // One ordinary case: inputs beside the words they should give.
  typedef struct packed
  {
    wiring_t w;
    data_format_t f;
    logic comms;
    logic cal;
    logic [15:0] under;
    logic [15:0] over;
    logic [15:0] cfv;
    logic [15:0] mfs;
    logic [31:0] pk;
  } row_t;

  logic sys_clk = 1'b0;
  logic rst_n;
  logic update_tick;
  wiring_t wiring_mode;
  data_format_t data_format;
  logic comms_fault;
  logic cal_busy;
  logic [15:0] cal_done;
  logic [15:0] cal_bad;
  chan_cond_t [15:0] chan_cond;
  logic [15:0][ALARM_W-1:0] alarm_latch_en;
  logic [15:0][ALARM_W-1:0] alarm_unlatch;
  logic [15:0] mfs;
  logic [15:0] cfv;
  logic [15:0][7:0] status;
  logic [31:0] packed_w;
  logic [15:0] rx_module;
  logic [15:0] rx_channel;
  int err_total = 0;
  int comparisons = 0;
  row_t r;
  logic [15:0] act;
  logic [7:0] exp_st;

  // Rows of ordinary cases; cal and comms rows keep range inputs quiet.
  row_t rows [11] = '{
    '{WIRE_SINGLE, FMT_FLOAT, 1'b0, 1'b0, 16'h0001, 16'h8000, 16'h8001, 16'h8000, 32'h0000_0000},
    '{WIRE_DIFF, FMT_FLOAT, 1'b0, 1'b0, 16'h0102, 16'h0000, 16'h0002, 16'h8000, 32'h0000_0000},
    '{WIRE_HS_DIFF, FMT_INTEGER, 1'b0, 1'b0, 16'h0008, 16'h0011, 16'h0009, 16'h8000, 32'h4200_0000},
    '{WIRE_HS_DIFF, FMT_FLOAT, 1'b0, 1'b0, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 32'h0000_0000},
    '{WIRE_SINGLE, FMT_INTEGER, 1'b0, 1'b0, 16'h8001, 16'h8000, 16'h8001, 16'h8000, 32'h8000_0003},
    '{WIRE_SINGLE, FMT_INTEGER, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'hFFFF, 16'h8400, 32'h0000_0000},
    '{WIRE_DIFF, FMT_FLOAT, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h00FF, 16'h8400, 32'h0000_0000},
    '{WIRE_HS_DIFF, FMT_FLOAT, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h000F, 16'h8400, 32'h0000_0000},
    '{WIRE_HS_DIFF, FMT_FLOAT, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'hFFFF, 16'h8400, 32'h0000_0000},
    '{WIRE_DIFF, FMT_INTEGER, 1'b1, 1'b0, 16'h0000, 16'h0000, 16'hFFFF, 16'h8000, 32'h0000_0000},
    '{WIRE_SINGLE, FMT_FLOAT, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 32'h0000_0000}
  };

  // Design under test with the full channel count.
  fault_status_aggregator #(.CHANNELS(NUM_CH)) i_fault_status_aggregator
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .update_tick(update_tick),
    .wiring_mode(wiring_mode),
    .data_format(data_format),
    .comms_fault(comms_fault),
    .cal_busy(cal_busy),
    .cal_done(cal_done),
    .cal_bad(cal_bad),
    .chan_cond(chan_cond),
    .alarm_latch_en(alarm_latch_en),
    .alarm_unlatch(alarm_unlatch),
    .module_fault_summary(mfs),
    .channel_fault_vector(cfv),
    .per_channel_status(status),
    .packed_range_status_integer(packed_w)
  );

  // Far side that receives the multicast words.
  owner_controller_model i_owner_controller_model
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .update_tick(update_tick),
    .module_fault_summary(mfs),
    .channel_fault_vector(cfv),
    .rx_module(rx_module),
    .rx_channel(rx_channel)
  );

  // 50 MHz clock.
  always #10 sys_clk = ~sys_clk;

  // Channels in use for a wiring mode.
  function automatic logic [15:0] act_mask(input wiring_t w);
    return (w == WIRE_DIFF) ? 16'h00FF : (w == WIRE_HS_DIFF) ? 16'h000F : 16'hFFFF;
  endfunction

  // Compares one result word and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One update pulse; waits until the controller holds the frame as well.
  task automatic tick;
    update_tick <= 1'b1;
    @(posedge sys_clk);
    update_tick <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // One alarm step on channel 1 and the level its bit should then show.
  task automatic alarm_step(input int b, input logic tr, input logic ok, input logic unl, input logic e);
    chan_cond[1].trip[b] <= tr;
    chan_cond[1].clear_ok[b] <= ok;
    alarm_unlatch[1][b] <= unl;
    tick;
    chk(32'(status[1][b]), 32'(e));
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop;
  end

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial
  begin
    rst_n <= 1'b0;
    update_tick <= 1'b0;
    wiring_mode <= WIRE_SINGLE;
    data_format <= FMT_FLOAT;
    comms_fault <= 1'b0;
    cal_busy <= 1'b0;
    cal_done <= 16'h0000;
    cal_bad <= 16'h0000;
    chan_cond <= '0;
    alarm_latch_en <= '0;
    alarm_unlatch <= '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk({mfs, cfv}, 32'h0000_0000);
    chk(packed_w, 32'h0000_0000);
    // Table of ordinary cases; status bytes checked channel by channel.
    for (int i = 0; i < 11; i++)
    begin
      r = rows[i];
      wiring_mode <= r.w;
      data_format <= r.f;
      comms_fault <= r.comms;
      cal_busy <= r.cal;
      for (int n = 0; n < 16; n++)
      begin
        chan_cond[n].at_min <= r.under[n];
        chan_cond[n].at_max <= r.over[n];
      end
      tick;
      chk(32'(rx_channel), 32'(r.cfv));
      chk(32'(rx_module), 32'(r.mfs));
      chk(packed_w, r.pk);
      act = act_mask(r.w) & {16{r.f == FMT_FLOAT}};
      for (int n = 0; n < 16; n++)
      begin
        exp_st = {1'b0, r.under[n] & act[n], r.over[n] & act[n], 5'h00};
        chk(32'(status[n]), 32'(exp_st));
      end
    end
    // Each alarm, first following its clear condition, then latched.
    wiring_mode <= WIRE_DIFF;
    for (int b = 0; b < ALARM_W; b++)
    begin
      alarm_step(b, 1'b1, 1'b0, 1'b0, 1'b1);
      alarm_step(b, 1'b0, 1'b0, 1'b0, 1'b1);
      alarm_step(b, 1'b0, 1'b1, 1'b0, 1'b0);
      alarm_latch_en[1][b] <= 1'b1;
      alarm_step(b, 1'b1, 1'b0, 1'b0, 1'b1);
      alarm_step(b, 1'b0, 1'b1, 1'b0, 1'b1);
      alarm_step(b, 1'b0, 1'b1, 1'b1, 1'b0);
      alarm_latch_en[1][b] <= 1'b0;
      chan_cond[1].clear_ok[b] <= 1'b0;
      alarm_unlatch[1][b] <= 1'b0;
    end
    // Alarms are absent in float single-ended and in integer mode.
    wiring_mode <= WIRE_SINGLE;
    chan_cond[1].trip <= 5'h1F;
    tick;
    chk(32'(status[1]), 32'h0000_0000);
    wiring_mode <= WIRE_DIFF;
    data_format <= FMT_INTEGER;
    tick;
    chk(32'(status[1]), 32'h0000_0000);
    // A bad calibration on channel 2 reaches the module word in both formats.
    chan_cond[1].trip <= 5'h00;
    data_format <= FMT_FLOAT;
    cal_done <= 16'h0004;
    cal_bad <= 16'h0004;
    @(posedge sys_clk);
    cal_done <= 16'h0000;
    cal_bad <= 16'h0000;
    tick;
    chk(32'(status[2]), 32'h0000_0080);
    chk(32'(rx_module), 32'h0000_0200);
    data_format <= FMT_INTEGER;
    tick;
    chk(32'(rx_module), 32'h0000_0200);
    // A good calibration replaces the error.
    cal_done <= 16'h0004;
    @(posedge sys_clk);
    cal_done <= 16'h0000;
    tick;
    chk(32'(rx_module), 32'h0000_0000);
    // Reset in mid-run clears a forced word at once.
    comms_fault <= 1'b1;
    tick;
    chk(32'(cfv), 32'h0000_FFFF);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk({mfs, cfv}, 32'h0000_0000);
    // A tick on the first edge after release is taken at once.
    rst_n <= 1'b1;
    tick;
    chk(32'(rx_channel), 32'h0000_FFFF);
    chk(32'(rx_module), 32'h0000_8000);
    report_and_stop;
  end
endmodule
`default_nettype wire
